// ---- rtl/sbs_pkg.sv ----
// Shared constants and types for the synthesizer band-select controller.
// Assumes a single 50 MHz system clock that also paces the reference divider.
package sbs_pkg;

   // Register map, byte offsets on the two-wire bus.
   localparam logic [7:0] REG_INT_UP    = 8'h00;
   localparam logic [7:0] REG_INT_LO    = 8'h01;
   localparam logic [7:0] REG_FRAC_TOP  = 8'h02;
   localparam logic [7:0] REG_FRAC_UP   = 8'h03;
   localparam logic [7:0] REG_FRAC_LO   = 8'h04;
   localparam logic [7:0] REG_REF_DIV   = 8'h05;
   localparam logic [7:0] REG_LOOP_OPT  = 8'h06;
   localparam logic [7:0] REG_VCO       = 8'h07;
   localparam logic [7:0] REG_CTRL      = 8'h09;
   localparam logic [7:0] REG_TEST      = 8'h0B;
   localparam logic [7:0] REG_STAT1     = 8'h0C;
   localparam logic [7:0] REG_STAT2     = 8'h0D;
   localparam logic [7:0] NUM_STORE     = 8'h0C;

   // Field positions.
   localparam int VCO_BAND_HI    = 7;
   localparam int VCO_BAND_LO    = 3;
   localparam int VCO_SEARCH_BIT = 2;
   localparam int VCO_LATCH_BIT  = 1;
   localparam int VCO_CONV_BIT   = 0;
   localparam int CTRL_HOLD_BIT  = 7;
   localparam int TEST_FAST_BIT  = 3;
   localparam int LOOP_A_BIT     = 7;
   localparam int PUMP_MODE_BIT  = 6;
   localparam int PUMP_LVL_HI    = 4;

   // Reset values; the fast-lock bit defaults to one.
   localparam logic [7:0] RST_TEST  = 8'h08;
   localparam logic [7:0] RST_OTHER = 8'h00;

   // Band range and converter code thresholds.
   localparam logic [4:0] BAND_MAX    = 5'h17;
   localparam logic [4:0] STEP_LIMIT  = 5'h17;
   localparam logic [2:0] CODE_VAS_MIN = 3'h2;
   localparam logic [2:0] CODE_VAS_MAX = 3'h5;
   localparam logic [2:0] CODE_OUT_LO  = 3'h0;
   localparam logic [2:0] CODE_OUT_HI  = 3'h7;

   // Settling time allowed for the tune voltage after each band step.
   localparam int CLK_NS     = 20;
   localparam int SETTLE_NS  = 10000;
   localparam logic [9:0] SETTLE_CYC = 10'((SETTLE_NS + CLK_NS - 1) / CLK_NS);

   // Bus address; the low bit comes from the address-select pin (value arbitrary).
   localparam logic [6:0] DEV_ADDR_BASE = 7'h60;

   typedef enum logic [1:0] {S_IDLE, S_SETTLE, S_EVAL} sbs_search_t;
   typedef enum logic [2:0] {P_IDLE, P_RX, P_RACK, P_TX, P_TACK} sbs_phase_t;

endpackage

// ---- rtl/sbs_twowire_slave.sv ----
// Two-wire bus slave: address match, register pointer, auto-increment reads and writes.
// Assumes the bus pins are asynchronous to clk and the bus clock is far slower than clk.
`timescale 1ns/10ps
module sbs_twowire_slave
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       scl,
   input  wire logic       sda_sense,
   input  wire logic       addr_sel,
   input  wire logic [7:0] rd_data,
   output logic            sda_oe_n,
   output logic [7:0]      ptr,
   output logic            wr_stb,
   output logic [7:0]      wr_addr,
   output logic [7:0]      wr_data,
   output logic            rd_stb,
   output logic [7:0]      rd_addr,
   output logic            start_stb,
   output logic            stop_stb
);
   import sbs_pkg::*;

   logic       scl_s1_q, scl_s2_q, scl_d_q;
   logic       sda_s1_q, sda_s2_q, sda_d_q;
   logic       asel_s1_q, asel_s2_q;
   logic [7:0] shift_q;
   logic [3:0] bit_q;
   logic [1:0] byte_q;
   logic       rw_q;
   logic       ack_q;
   sbs_phase_t phase_q;
   logic       scl_rise, scl_fall, start_c, stop_c, load_c;

   ////////////////////////////////////////////////////////////////////////////////////////
   // Two flops per pin plus a third on scl and sda; edge detection only looks at the second stage onward.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         {scl_s1_q, scl_s2_q, scl_d_q} <= 3'h7;
         {sda_s1_q, sda_s2_q, sda_d_q} <= 3'h7;
         {asel_s1_q, asel_s2_q}        <= 2'h0;
      end
      else
      begin
         {scl_s1_q, scl_s2_q, scl_d_q} <= {scl, scl_s1_q, scl_s2_q};
         {sda_s1_q, sda_s2_q, sda_d_q} <= {sda_sense, sda_s1_q, sda_s2_q};
         {asel_s1_q, asel_s2_q}        <= {addr_sel, asel_s1_q};
      end
   end

   // Start and stop are data edges while the clock stays high.
   assign scl_rise = scl_s2_q & ~scl_d_q;
   assign scl_fall = ~scl_s2_q & scl_d_q;
   assign start_c  = scl_s2_q & scl_d_q & sda_d_q & ~sda_s2_q;
   assign stop_c   = scl_s2_q & scl_d_q & ~sda_d_q & sda_s2_q;
   assign load_c   = scl_fall & ((phase_q == P_RACK & rw_q) | (phase_q == P_TACK & ack_q));
   assign ptr      = rd_addr;

   ////////////////////////////////////////////////////////////////////////////////////////
   // Byte engine; read data is fetched at the falling edge that ends the acknowledge.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         phase_q   <= P_IDLE;
         shift_q   <= 8'h00;
         bit_q     <= 4'h0;
         byte_q    <= 2'h0;
         rw_q      <= 1'b0;
         ack_q     <= 1'b0;
         sda_oe_n  <= 1'b1;
         wr_stb    <= 1'b0;
         wr_addr   <= 8'h00;
         wr_data   <= 8'h00;
         rd_stb    <= 1'b0;
         rd_addr   <= 8'h00;
         start_stb <= 1'b0;
         stop_stb  <= 1'b0;
      end
      else
      begin
         wr_stb    <= 1'b0;
         rd_stb    <= 1'b0;
         start_stb <= start_c;
         stop_stb  <= stop_c;
         if (stop_c)
         begin
            phase_q  <= P_IDLE;
            sda_oe_n <= 1'b1;
         end
         else if (start_c)
         begin
            phase_q  <= P_RX;
            bit_q    <= 4'h0;
            byte_q   <= 2'h0;
            sda_oe_n <= 1'b1;
         end
         else if (load_c)
         begin
            shift_q  <= rd_data;
            sda_oe_n <= rd_data[7];
            bit_q    <= 4'h0;
            rd_stb   <= 1'b1;
            rd_addr  <= rd_addr + 8'h01;
            phase_q  <= P_TX;
         end
         else
         begin
            unique case (phase_q)
               P_IDLE: ;
               P_RX:
                  if (scl_rise && bit_q < 4'h8)
                  begin
                     shift_q <= {shift_q[6:0], sda_s2_q};
                     bit_q   <= bit_q + 4'h1;
                  end
                  else if (scl_fall && bit_q == 4'h8)
                  begin
                     bit_q <= 4'h0;
                     if (byte_q == 2'h0)
                     begin
                        if (shift_q[7:1] == {DEV_ADDR_BASE[6:1], asel_s2_q})
                        begin
                           rw_q     <= shift_q[0];
                           sda_oe_n <= 1'b0;
                           phase_q  <= P_RACK;
                           byte_q   <= 2'h1;
                        end
                        else
                           phase_q <= P_IDLE;
                     end
                     else
                     begin
                        sda_oe_n <= 1'b0;
                        phase_q  <= P_RACK;
                        byte_q   <= 2'h2;
                        if (byte_q == 2'h1)
                           rd_addr <= shift_q;
                        else
                        begin
                           wr_stb  <= 1'b1;
                           wr_addr <= rd_addr;
                           wr_data <= shift_q;
                           rd_addr <= rd_addr + 8'h01;
                        end
                     end
                  end
               P_RACK:
                  if (scl_fall)
                  begin
                     sda_oe_n <= 1'b1;
                     phase_q  <= P_RX;
                  end
               P_TX:
                  if (scl_fall)
                  begin
                     if (bit_q == 4'h7)
                     begin
                        sda_oe_n <= 1'b1;
                        phase_q  <= P_TACK;
                     end
                     else
                     begin
                        shift_q  <= {shift_q[6:0], 1'b0};
                        sda_oe_n <= shift_q[6];
                        bit_q    <= bit_q + 4'h1;
                     end
                  end
               P_TACK:
                  if (scl_rise)
                     ack_q <= ~sda_s2_q;
                  else if (scl_fall)
                     phase_q <= P_IDLE;
               default: phase_q <= P_IDLE;
            endcase
         end
      end
   end

endmodule

// ---- rtl/sbs_synth_ctrl.sv ----
// Synthesizer control top: register file, band search, tune converter capture, standby.
// Assumes clk is the crystal reference and the bus host reprograms all registers after power-up.
`timescale 1ns/10ps
// Functional notes
// - Divide words are plain unsigned binary, fifteen-bit integer.
// - Five-bit reference ratio divides the crystal clock.
// - Twenty-four bands, selectable through five-bit field.
// - Band in use reads back in status two.
// - Low fraction byte write launches enabled search.
// - Search starts from the manual band value.
// - Idle flag stays low while searching.
// - Success sets idle and success, reports band.
// - Failed search clears success, sets idle.
// - Three-bit tune code classifies lock state.
// - Search accepts only search-locked code range.
// - Converter code latched only on latch-bit write.
// - Standby halts everything except the bus and the tune converter.
// - Register contents survive standby unchanged.
// - Power-up flag clears after status read plus stop.
// - Success flag bit six, idle bit five.
module sbs_synth_ctrl
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        scl,
   input  wire logic        sda_sense,
   output logic             sda_drive,
   output logic             sda_oe_n,
   input  wire logic        addr_sel,
   input  wire logic [2:0]  tune_voltage_pin,
   output logic [14:0]      int_divide,
   output logic [19:0]      frac_divide,
   output logic [4:0]       ref_divide,
   output logic             comp_tick,
   output logic [4:0]       vco_band,
   output logic             synth_enable,
   output logic             tune_converter_enable,
   output logic             low_power_hold,
   output logic             fast_lock_select,
   output logic             lock_indicator,
   output logic             loop_option_a,
   output logic             pump_current_mode,
   output logic [4:0]       pump_current_level
);
   import sbs_pkg::*;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   logic [7:0]  regs_q [0:11];
   logic [7:0]  rd_data, ptr, wr_addr, wr_data, rd_addr;
   logic        wr_stb, rd_stb, start_stb, stop_stb, bus_oe_n;
   logic [2:0]  code_s1_q, code_s2_q, adc_q;
   logic        por_q, stat1_seen_q, ld_q, idle_q, ok_q, synth_en_q;
   logic [4:0]  band_q, steps_q, ref_cnt_q;
   logic [9:0]  settle_q;
   logic        tick_q;
   sbs_search_t st_q;
   logic [7:0]  vco_q, ctrl_q, test_q;
   logic [4:0]  manual_band, ref_ratio;
   logic        hold_q, search_en, low_byte_wr, code_vas, code_low, code_high, step_fail;

   // Search-locked band: middle codes, leaving margin for drift.
   function automatic logic in_vas_range(input logic [2:0] code);
      in_vas_range = (code >= CODE_VAS_MIN) && (code <= CODE_VAS_MAX);
   endfunction

   // Locked band: everything but the two extreme codes.
   function automatic logic in_lock_range(input logic [2:0] code);
      in_lock_range = (code != CODE_OUT_LO) && (code != CODE_OUT_HI);
   endfunction

   // Bands above the last one fold onto the last one.
   function automatic logic [4:0] clamp_band(input logic [4:0] b);
      clamp_band = (b > BAND_MAX) ? BAND_MAX : b;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////////////
   // Bus slave.
   sbs_twowire_slave u_bus
   (
      .clk       (clk),
      .rst       (rst),
      .scl       (scl),
      .sda_sense (sda_sense),
      .addr_sel  (addr_sel),
      .rd_data   (rd_data),
      .sda_oe_n  (bus_oe_n),
      .ptr       (ptr),
      .wr_stb    (wr_stb),
      .wr_addr   (wr_addr),
      .wr_data   (wr_data),
      .rd_stb    (rd_stb),
      .rd_addr   (rd_addr),
      .start_stb (start_stb),
      .stop_stb  (stop_stb)
   );

   // The pin is open-drain, so the driven level is always low.
   always_ff @(posedge clk)
   begin
      if (rst)
         sda_drive <= 1'b0;
      else
         sda_drive <= 1'b0;
   end
   assign sda_oe_n = bus_oe_n;

   ////////////////////////////////////////////////////////////////////////////////////////
   // Register file; standby never touches it, so settings persist across it.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         for (int i = 0; i < 12; i++)
            regs_q[i] <= (i == int'(REG_TEST)) ? RST_TEST : RST_OTHER;
      end
      else if (wr_stb && wr_addr < NUM_STORE)
         regs_q[wr_addr[3:0]] <= wr_data;
   end

   assign vco_q       = regs_q[REG_VCO[3:0]];
   assign ctrl_q      = regs_q[REG_CTRL[3:0]];
   assign test_q      = regs_q[REG_TEST[3:0]];
   assign hold_q      = ctrl_q[CTRL_HOLD_BIT];
   assign search_en   = vco_q[VCO_SEARCH_BIT];
   assign manual_band = vco_q[VCO_BAND_HI:VCO_BAND_LO];
   assign low_byte_wr = wr_stb && (wr_addr == REG_FRAC_LO);

   // Divide words are straight binary slices of the stored bytes.
   assign int_divide  = {regs_q[REG_INT_UP[3:0]][6:0], regs_q[REG_INT_LO[3:0]]};
   assign frac_divide = {regs_q[REG_FRAC_TOP[3:0]][3:0], regs_q[REG_FRAC_UP[3:0]],
                         regs_q[REG_FRAC_LO[3:0]]};
   assign ref_divide            = regs_q[REG_REF_DIV[3:0]][4:0];
   assign tune_converter_enable = vco_q[VCO_CONV_BIT];
   assign low_power_hold        = hold_q;
   assign fast_lock_select      = test_q[TEST_FAST_BIT];
   assign loop_option_a         = regs_q[REG_LOOP_OPT[3:0]][LOOP_A_BIT];
   assign pump_current_mode     = regs_q[REG_LOOP_OPT[3:0]][PUMP_MODE_BIT];
   assign pump_current_level    = regs_q[REG_LOOP_OPT[3:0]][PUMP_LVL_HI:0];
   assign vco_band              = band_q;
   assign synth_enable          = synth_en_q;
   assign lock_indicator        = ld_q;
   assign comp_tick             = tick_q;

   // Read data; all twelve stored bytes read back, addresses above status two return zero.
   always_comb
   begin
      rd_data = 8'h00;
      if (ptr < NUM_STORE)
         rd_data = regs_q[ptr[3:0]];
      else if (ptr == REG_STAT1)
         rd_data = {por_q, ok_q, idle_q, ld_q, 4'h0};
      else if (ptr == REG_STAT2)
         rd_data = {band_q, adc_q};
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Converter code arrives from the analog side; two flops before use. The bits are
   // not gray coded, so a code caught mid-transition may be off by several steps for one cycle.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         code_s1_q <= 3'h0;
         code_s2_q <= 3'h0;
      end
      else
      begin
         code_s1_q <= tune_voltage_pin;
         code_s2_q <= code_s1_q;
      end
   end

   assign code_vas  = in_vas_range(code_s2_q);
   assign code_low  = code_s2_q < CODE_VAS_MIN;
   assign code_high = code_s2_q > CODE_VAS_MAX;

   // Readback copy of the converter, refreshed only by a latch-bit write.
   always_ff @(posedge clk)
   begin
      if (rst)
         adc_q <= 3'h0;
      else if (wr_stb && wr_addr == REG_VCO && wr_data[VCO_LATCH_BIT])
         adc_q <= code_s2_q;
   end

   // Lock indication is only meaningful with fast lock selected.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         ld_q       <= 1'b0;
         synth_en_q <= 1'b0;
      end
      else
      begin
         ld_q       <= fast_lock_select & in_lock_range(code_s2_q) & ~hold_q;
         synth_en_q <= ~hold_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Comparison tick every ratio cycles of the crystal; a ratio of zero acts as one.
   assign ref_ratio = (ref_divide == 5'h00) ? 5'h01 : ref_divide;

   always_ff @(posedge clk)
   begin
      if (rst || hold_q)
      begin
         ref_cnt_q <= 5'h00;
         tick_q    <= 1'b0;
      end
      else if (ref_cnt_q >= ref_ratio - 5'h01)
      begin
         ref_cnt_q <= 5'h00;
         tick_q    <= 1'b1;
      end
      else
      begin
         ref_cnt_q <= ref_cnt_q + 5'h01;
         tick_q    <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Power-up flag: cleared by a stop that ends a transfer which read status byte one.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         por_q        <= 1'b1;
         stat1_seen_q <= 1'b0;
      end
      else
      begin
         if (start_stb)
            stat1_seen_q <= 1'b0;
         else if (rd_stb && (rd_addr - 8'h01) == REG_STAT1) // Pointer already moved on.
            stat1_seen_q <= 1'b1;
         if (stop_stb && stat1_seen_q)
            por_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Band search. The step direction follows the code: a low code steps the band down,
   // a high code steps it up. A step budget stops endless hunting between two bands.
   assign step_fail = (code_low && band_q == 5'h00) || (code_high && band_q == BAND_MAX)
                      || (steps_q == STEP_LIMIT);

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         st_q     <= S_IDLE;
         band_q   <= 5'h00;
         idle_q   <= 1'b1;
         ok_q     <= 1'b0;
         settle_q <= 10'h000;
         steps_q  <= 5'h00;
      end
      else if (hold_q)
      begin
         // Standby abandons a running search as unsuccessful.
         if (st_q != S_IDLE)
         begin
            st_q   <= S_IDLE;
            idle_q <= 1'b1;
            ok_q   <= 1'b0;
         end
      end
      else if (low_byte_wr && search_en)
      begin
         st_q     <= S_SETTLE;
         idle_q   <= 1'b0;
         band_q   <= clamp_band(manual_band);
         settle_q <= SETTLE_CYC;
         steps_q  <= 5'h00;
      end
      else if (low_byte_wr && st_q == S_IDLE)
         band_q <= clamp_band(manual_band);
      else
      begin
         unique case (st_q)
            S_IDLE: ;
            S_SETTLE:
               if (settle_q == 10'h000)
                  st_q <= S_EVAL;
               else
                  settle_q <= settle_q - 10'h001;
            S_EVAL:
               if (code_vas)
               begin
                  st_q   <= S_IDLE;
                  idle_q <= 1'b1;
                  ok_q   <= 1'b1;
               end
               else if (step_fail)
               begin
                  st_q   <= S_IDLE;
                  idle_q <= 1'b1;
                  ok_q   <= 1'b0;
               end
               else
               begin
                  band_q   <= code_low ? band_q - 5'h01 : band_q + 5'h01;
                  steps_q  <= steps_q + 5'h01;
                  settle_q <= SETTLE_CYC;
                  st_q     <= S_SETTLE;
               end
            default: st_q <= S_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Checks.
   sequence s_launch;
      low_byte_wr && search_en && !hold_q;
   endsequence

   sequence s_eval_live;
      st_q == S_EVAL && !hold_q && !low_byte_wr;
   endsequence

   a_busy_idle_low: assert property (st_q != S_IDLE |-> !idle_q)
      else $error("Idle flag high while a search runs.");
   a_launch_search: assert property (s_launch |=> st_q == S_SETTLE && !idle_q
                                     && band_q == clamp_band($past(manual_band)))
      else $error("Search did not launch from the manual band.");
   a_manual_apply: assert property (low_byte_wr && !search_en && !hold_q && st_q == S_IDLE
                                    |=> band_q == clamp_band($past(manual_band))
                                    && $stable(idle_q) && $stable(ok_q))
      else $error("Manual band not applied or flags disturbed.");
   a_accept_good: assert property (s_eval_live and code_vas |=> idle_q && ok_q
                                   && st_q == S_IDLE && $stable(band_q))
      else $error("Good band not reported as success.");
   a_reject_end: assert property (s_eval_live and !code_vas && step_fail
                                  |=> idle_q && !ok_q && st_q == S_IDLE)
      else $error("Failed search not reported.");
   a_ok_needs_code: assert property ($rose(ok_q) |-> $past(code_vas))
      else $error("Success raised outside the search-locked range.");
   a_adc_capture: assert property (wr_stb && wr_addr == REG_VCO && wr_data[VCO_LATCH_BIT]
                                   |=> adc_q == $past(code_s2_q))
      else $error("Converter code not latched.");
   a_adc_steady: assert property (!(wr_stb && wr_addr == REG_VCO) |=> $stable(adc_q))
      else $error("Converter readback changed without a latch write.");
   a_por_release: assert property ($fell(por_q) |-> $past(stop_stb) && $past(stat1_seen_q))
      else $error("Power-up flag cleared without status read and stop.");
   a_standby_halt: assert property (hold_q |=> st_q == S_IDLE && !synth_enable)
      else $error("Synthesizer still active in standby.");
   a_regs_kept: assert property (hold_q && !wr_stb |=> $stable(int_divide)
                                 && $stable(frac_divide))
      else $error("Divide settings changed in standby.");
   a_band_range: assert property (band_q <= BAND_MAX)
      else $error("Band beyond the last band.");

endmodule

// ---- verif/sbs_host_model.sv ----
// Two-wire bus host model: start, stop, nine-bit slots, register access.
// Assumes the bench clock paces it; sda_line is the wired-and data level.
`timescale 1ns/10ps
module sbs_host_model
(
   input  wire logic clk,
   input  wire logic sda_line,
   output logic      scl,
   output logic      sda_h
);
   // Idle bus: both wires released high and the clock stands still.
   initial {scl, sda_h} = 2'b11;
   // Start when s is 1, stop when 0; waits out an ack the device still holds.
   task automatic cond(input logic s);
      @(posedge clk) sda_h <= s;
      repeat (5) @(posedge clk);
      scl <= 1'b1;
      repeat (4) @(posedge clk);
      sda_h <= !s;
      repeat (4) @(posedge clk);
      scl <= !s;
   endtask
   // Nine bits MSB first, 160 ns each, sampled late in the high phase.
   task automatic xfer(input logic [8:0] d, output logic [8:0] r);
      for (int i = 8; i >= 0; i--)
      begin
         @(posedge clk) sda_h <= d[i];
         repeat (4) @(posedge clk);
         scl <= 1'b1;
         repeat (3) @(posedge clk);
         r[i] = sda_line;
         scl <= 1'b0;
      end
   endtask
   // One register write or read; a read sets the pointer, then restarts.
   task automatic acc(input logic rd, input logic [7:0] p, input logic [7:0] d,
                      output logic [7:0] q);
      logic [8:0] r;
      cond(1'b1);
      xfer({8'hC0, 1'b1}, r);
      xfer({p, 1'b1}, r);
      if (rd)
      begin
         cond(1'b1);
         xfer({8'hC1, 1'b1}, r);
      end
      xfer({rd ? 8'hFF : d, 1'b1}, r);
      q = r[8:1];
      cond(1'b0);
   endtask
endmodule

// ---- verif/tb_top.sv ----
// Bench: status reads, band search, manual band, latch and standby.
// Assumes the host model owns the bus pins and the bench sets the tune code.
`timescale 1ns/10ps
module tb_top;
   import sbs_pkg::*;
   logic        clk, rst, scl, sda_h, sda_drive, sda_oe_n, hold, tick;
   logic [15:0] outs;
   logic [19:0] frac;
   logic [2:0]  tune;
   logic [4:0]  band;
   logic [7:0]  q;
   logic [14:0] int_div;
   int          err_count = 0;
   int          check_count = 0;
   // Wired-and data line; the device only ever pulls low.
   wire         sda_line = sda_h & (sda_oe_n | sda_drive);
   sbs_host_model host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_h(sda_h));
   sbs_synth_ctrl dut (.clk(clk), .rst(rst), .scl(scl), .sda_sense(sda_line),
      .sda_drive(sda_drive), .sda_oe_n(sda_oe_n), .addr_sel(1'b0), .tune_voltage_pin(tune),
      .int_divide(int_div), .frac_divide(frac), .ref_divide(outs[15:11]), .comp_tick(tick),
      .vco_band(band), .synth_enable(outs[0]), .tune_converter_enable(outs[1]),
      .low_power_hold(hold), .fast_lock_select(outs[2]), .lock_indicator(outs[3]),
      .loop_option_a(outs[4]), .pump_current_mode(outs[5]), .pump_current_level(outs[10:6]));
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Counts every comparison and reports a mismatch on one line.
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      check_count++;
      if (g !== e)
      begin
         err_count++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      end
   endtask
   // Reads one register over the bus and compares it.
   task automatic rchk(input logic [7:0] p, input logic [7:0] e);
      host.acc(1'b1, p, 8'h00, q);
      chk($sformatf("reg %h", p), {8'h00, e}, {8'h00, q});
   endtask
   // Counts comparison ticks over 100 cycles, sampled mid-cycle to stay clear of the edge.
   task automatic tchk(input logic [15:0] e);
      int n;
      n = 0;
      repeat (100) @(negedge clk) n += int'(tick);
      chk("ticks", e, 16'(n));
   endtask
   task automatic wrap_up();
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Cuts a hang short; the run needs about 16500 cycles.
   initial
   begin
      repeat (40000) @(posedge clk);
      err_count++;
      wrap_up();
   end
   // Main sequence; search waits cover two settle periods with margin.
   initial
   begin
      rst = 1'b1;
      tune = 3'b011;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      repeat (5) @(posedge clk);
      rchk(REG_STAT1, 8'hB0);
      rchk(REG_STAT1, 8'h30);
      repeat (5000) @(posedge clk);
      host.acc(1'b0, REG_TEST, 8'h08, q);
      host.acc(1'b0, REG_INT_UP, 8'h12, q);
      host.acc(1'b0, REG_INT_LO, 8'h34, q);
      host.acc(1'b0, REG_FRAC_TOP, 8'h05, q);
      host.acc(1'b0, REG_FRAC_UP, 8'hED, q);
      host.acc(1'b0, REG_REF_DIV, 8'h05, q);
      host.acc(1'b0, REG_LOOP_OPT, 8'hD3, q);
      chk("int", 16'h1234, {1'b0, int_div});
      host.acc(1'b0, REG_VCO, 8'h2D, q);
      chk("outs", 16'h2CFF, outs);
      host.acc(1'b0, REG_FRAC_LO, 8'h09, q);
      chk("frac", 16'h5ED0, frac[19:4]);
      rchk(REG_STAT1, 8'h10);
      repeat (2000) @(posedge clk);
      tchk(16'd20);
      rchk(REG_STAT1, 8'h70);
      rchk(REG_STAT2, 8'h28);
      tune <= 3'b111;
      host.acc(1'b0, REG_VCO, 8'hB5, q);
      host.acc(1'b0, REG_FRAC_LO, 8'h00, q);
      repeat (3000) @(posedge clk);
      rchk(REG_STAT1, 8'h20);
      host.acc(1'b0, REG_VCO, 8'h4B, q);
      host.acc(1'b0, REG_FRAC_LO, 8'h00, q);
      rchk(REG_STAT1, 8'h20);
      rchk(REG_STAT2, 8'h4F);
      host.acc(1'b0, REG_CTRL, 8'h80, q);
      chk("hold", 16'h0001, {15'h0000, hold});
      chk("outs", 16'h2CF6, outs);
      tchk(16'd0);
      chk("int", 16'h1234, {1'b0, int_div});
      host.acc(1'b0, REG_CTRL, 8'h00, q);
      chk("outs", 16'h2CF7, outs);
      chk("band", 16'h0009, {11'h000, band});
      wrap_up();
   end
endmodule
